//--- hdl/ardm_defs.vh
// Constants and register layout of the result data modification block
// Behaviour
// R1: Reduction mode: 0000 off, n sums n+1
// R2: Mode 01 selects filtering by control field
// R3: FIR gain equals coefficient sum, 14-bit result
// R4: IIR sets give gain 4, 14-bit result
// R5: Codes 0000-0100 pick FIR sets summing three
// R6: Codes 0101-1101 pick FIR sets summing four
// R7: Code 1110 selects IIR a=2 b=2
// R8: Code 1111 selects IIR a=3 b=4
// R9: Software divides by coefficient sum or 4
// R10: Software primes history or drops early outputs
// R11: Valid flag and counter shown per result
// R12: Reduction event only after final accumulation
// R13: Filtering only on registers 7 and 15
// R14: Unread result keeps valid flag set
// R15: FIR uses two-entry history per filtered register
// R16: Counter loads, decrements, reaches zero at end
`ifndef ARDM_DEFS_VH
`define ARDM_DEFS_VH

`define ARDM_NRES         16
`define ARDM_ADR_W        8
`define ARDM_CTL_BASE     8'h00
`define ARDM_VAL_BASE     8'h40
`define ARDM_STS_ADR      8'h80
`define ARDM_MSK_ADR      8'h84
`define ARDM_BLK_MSK      8'hc0
`define ARDM_IDX_LSB      2
`define ARDM_IDX_MSB      5

`define ARDM_MODE_LSB     0
`define ARDM_MODE_MSB     1
`define ARDM_CTR_LSB      4
`define ARDM_CTR_MSB      7
`define ARDM_VAL_MSB      15
`define ARDM_CNT_LSB      16
`define ARDM_CNT_MSB      19
`define ARDM_VLD_BIT      31

`define ARDM_MODE_RED     2'h0
`define ARDM_MODE_FILT    2'h1
`define ARDM_CTR_OFF      4'h0
`define ARDM_CTR_IIR_A    4'he
`define ARDM_CTR_IIR_B    4'hf
`define ARDM_FILT_IDX_LO  4'h7
`define ARDM_FILT_IDX_HI  4'hf

`endif

//--- hdl/ardm_filt.v
// Combinational FIR and IIR arithmetic for one filtered result register
`include "ardm_defs.vh"

module ardm_filt (
  // Selection
  input  wire [3:0]  ctrl,
  // Samples
  input  wire [11:0] smp_new,
  input  wire [11:0] smp_prev1,
  input  wire [11:0] smp_prev2,
  input  wire [15:0] out_prev,
  // Result
  output reg  [13:0] flt_out
);

  // Coefficients {a,b,c}, two bits each
  function [5:0] fir_coef;
    input [3:0] code;
    begin
      case (code)
        4'h0:    fir_coef = {2'h2, 2'h1, 2'h0}; // R5
        4'h1:    fir_coef = {2'h1, 2'h2, 2'h0}; // R5
        4'h2:    fir_coef = {2'h2, 2'h0, 2'h1}; // R5
        4'h3:    fir_coef = {2'h1, 2'h1, 2'h1}; // R5
        4'h4:    fir_coef = {2'h1, 2'h0, 2'h2}; // R5
        4'h5:    fir_coef = {2'h3, 2'h1, 2'h0}; // R6
        4'h6:    fir_coef = {2'h2, 2'h2, 2'h0}; // R6
        4'h7:    fir_coef = {2'h1, 2'h3, 2'h0}; // R6
        4'h8:    fir_coef = {2'h3, 2'h0, 2'h1}; // R6
        4'h9:    fir_coef = {2'h2, 2'h1, 2'h1}; // R6
        4'ha:    fir_coef = {2'h1, 2'h2, 2'h1}; // R6
        4'hb:    fir_coef = {2'h2, 2'h0, 2'h2}; // R6
        4'hc:    fir_coef = {2'h1, 2'h1, 2'h2}; // R6
        4'hd:    fir_coef = {2'h1, 2'h0, 2'h3}; // R6
        default: fir_coef = 6'h00;
      endcase
    end
  endfunction

  reg [5:0]  cf;
  reg [15:0] acc;

  // Coefficient sums never exceed 4, so 14 bits always hold the result
  always @* begin
    cf  = fir_coef(ctrl);
    acc = 16'h0000;
    if (ctrl == `ARDM_CTR_IIR_A) begin
      acc = {3'h0, smp_new, 1'b0} + {3'h0, out_prev[13:1]}; // R7 R4
    end else if (ctrl == `ARDM_CTR_IIR_B) begin
      acc = ({3'h0, smp_new, 1'b0} + {4'h0, smp_new}) + {4'h0, out_prev[13:2]}; // R8 R4
    end else begin
      acc = ({2'h0, cf[5:4]} * {4'h0, smp_new})
          + ({2'h0, cf[3:2]} * {4'h0, smp_prev1})
          + ({2'h0, cf[1:0]} * {4'h0, smp_prev2}); // R15 R3
    end
    flt_out = acc[13:0]; // R3
  end

endmodule

//--- hdl/ardm_top.v
// Result data modification: reduction, filtering, registers and interrupt
`include "ardm_defs.vh"

module ardm_top (
  // Clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        ce,
  // Conversion results
  input  wire        conv_vld,
  input  wire [3:0]  conv_sel,
  input  wire [11:0] conv_res,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_ff,
  // Interrupt
  output reg         irq_ff
);

  reg [1:0]  modification_mode_field_ff [0:`ARDM_NRES-1];
  reg [3:0]  reduction_control_field_ff [0:`ARDM_NRES-1];
  reg [15:0] result_value_reg_ff        [0:`ARDM_NRES-1];
  reg [3:0]  reduction_counter_ff       [0:`ARDM_NRES-1];
  reg [15:0] result_valid_flag_ff;
  reg [15:0] evt_sts_ff;
  reg [15:0] evt_msk_ff;
  reg [11:0] hist1_ff [0:1];
  reg [11:0] hist2_ff [0:1];

  integer i;

  // Filtering exists only on the top register of each group of eight
  function is_filt_slot;
    input [3:0] idx;
    begin
      is_filt_slot = (idx == `ARDM_FILT_IDX_LO) || (idx == `ARDM_FILT_IDX_HI); // R13
    end
  endfunction

  function [3:0] adr_idx;
    input [7:0] adr;
    begin
      adr_idx = adr[`ARDM_IDX_MSB:`ARDM_IDX_LSB];
    end
  endfunction

  wire [3:0]  cidx   = conv_sel;
  wire        fslot  = conv_sel[3];
  wire [1:0]  cmode  = modification_mode_field_ff[cidx];
  wire [3:0]  cctrl  = reduction_control_field_ff[cidx];
  wire [3:0]  ccnt   = reduction_counter_ff[cidx];
  wire [15:0] cval   = result_value_reg_ff[cidx];
  wire        do_flt = (cmode == `ARDM_MODE_FILT) && is_filt_slot(cidx); // R2 R13
  wire        do_red = (cmode == `ARDM_MODE_RED) && (cctrl != `ARDM_CTR_OFF); // R1
  wire [13:0] flt_val;
  wire [15:0] sum_val = cval + {4'h0, conv_res};
  wire [3:0]  dec_cnt = ccnt - 4'h1;

  ardm_filt u_filt (
    .ctrl      (cctrl),
    .smp_new   (conv_res),
    .smp_prev1 (hist1_ff[fslot]),
    .smp_prev2 (hist2_ff[fslot]),
    .out_prev  (cval),
    .flt_out   (flt_val)
  );

  wire [3:0] aidx   = adr_idx(reg_addr);
  wire       a_ctl  = (reg_addr & `ARDM_BLK_MSK) == `ARDM_CTL_BASE;
  wire       a_val  = (reg_addr & `ARDM_BLK_MSK) == `ARDM_VAL_BASE;
  wire       a_sts  = reg_addr == `ARDM_STS_ADR;
  wire       a_msk  = reg_addr == `ARDM_MSK_ADR;
  wire       a_algn = reg_addr[1:0] == 2'h0;

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (!a_algn) begin
      rd_mux = 32'h0000_0000;
    end else if (a_ctl) begin
      rd_mux[`ARDM_MODE_MSB:`ARDM_MODE_LSB] = modification_mode_field_ff[aidx];
      rd_mux[`ARDM_CTR_MSB:`ARDM_CTR_LSB]   = reduction_control_field_ff[aidx];
    end else if (a_val) begin
      rd_mux[`ARDM_VAL_MSB:0]               = result_value_reg_ff[aidx];
      rd_mux[`ARDM_CNT_MSB:`ARDM_CNT_LSB]   = reduction_counter_ff[aidx]; // R11
      rd_mux[`ARDM_VLD_BIT]                 = result_valid_flag_ff[aidx]; // R11
    end else if (a_sts) begin
      rd_mux[15:0] = evt_sts_ff;
    end else if (a_msk) begin
      rd_mux[15:0] = evt_msk_ff;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      for (i = 0; i < `ARDM_NRES; i = i + 1) begin
        modification_mode_field_ff[i] <= `ARDM_MODE_RED;
        reduction_control_field_ff[i] <= `ARDM_CTR_OFF;
        result_value_reg_ff[i]        <= 16'h0000;
        reduction_counter_ff[i]       <= 4'h0;
      end
      for (i = 0; i < 2; i = i + 1) begin
        hist1_ff[i] <= 12'h000;
        hist2_ff[i] <= 12'h000;
      end
      result_valid_flag_ff <= 16'h0000;
      evt_sts_ff           <= 16'h0000;
      evt_msk_ff           <= 16'h0000;
      reg_rdata_ff         <= 32'h0000_0000;
      irq_ff               <= 1'b0;
    end else if (ce) begin
      // Read data live for one cycle only
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
      irq_ff       <= |(evt_sts_ff & evt_msk_ff);

      // Clears first, so that a same-cycle hardware set below wins
      if (reg_rd && a_algn && a_val) begin
        result_valid_flag_ff[aidx] <= 1'b0;
      end
      if (reg_rd && a_sts) begin
        evt_sts_ff <= 16'h0000;
      end
      if (reg_wr && a_algn && a_ctl) begin
        modification_mode_field_ff[aidx] <= reg_wdata[`ARDM_MODE_MSB:`ARDM_MODE_LSB];
        reduction_control_field_ff[aidx] <= reg_wdata[`ARDM_CTR_MSB:`ARDM_CTR_LSB];
        // New setting restarts any pending sequence
        reduction_counter_ff[aidx]       <= 4'h0;
      end
      if (reg_wr && a_msk) begin
        evt_msk_ff <= reg_wdata[15:0];
      end

      if (conv_vld) begin
        if (do_flt) begin
          result_value_reg_ff[cidx]  <= {2'h0, flt_val}; // R2 R3 R4
          hist1_ff[fslot]            <= conv_res; // R15
          hist2_ff[fslot]            <= hist1_ff[fslot]; // R15
          result_valid_flag_ff[cidx] <= 1'b1;
          evt_sts_ff[cidx]           <= 1'b1;
        end else if (do_red) begin
          if (ccnt == 4'h0) begin
            // First value of a sequence; old valid flag is left alone
            result_value_reg_ff[cidx]  <= {4'h0, conv_res}; // R14
            reduction_counter_ff[cidx] <= cctrl; // R16
          end else begin
            result_value_reg_ff[cidx]  <= sum_val; // R1
            reduction_counter_ff[cidx] <= dec_cnt; // R16
            if (dec_cnt == 4'h0) begin
              result_valid_flag_ff[cidx] <= 1'b1; // R12
              evt_sts_ff[cidx]           <= 1'b1; // R12
            end
          end
        end else begin
          // Plain store: reduction off, or mode without support here
          result_value_reg_ff[cidx]  <= {4'h0, conv_res}; // R1
          reduction_counter_ff[cidx] <= 4'h0;
          result_valid_flag_ff[cidx] <= 1'b1;
          evt_sts_ff[cidx]           <= 1'b1;
        end
      end
    end
  end

endmodule

//--- test/ardm_props.sv
// Port assertions for the result data modification block
module ardm_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        ce,
  // Conversion results
  input wire logic        conv_vld,
  input wire logic [3:0]  conv_sel,
  input wire logic [11:0] conv_res,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  // Interrupt
  input wire logic        irq_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] ctl0_ff;
  wire        pl0 = conv_vld && conv_sel == 4'h0 && ctl0_ff[1:0] == 2'h0 && ctl0_ff[7:4] == 4'h0;
  wire        rd_sts = reg_rd && reg_addr == 8'h80;
  // Control 0 shadow; plain store checked only while mode and control fields are zero
  always @(posedge mclk) begin
    ctl0_ff <= sys_rst ? 8'h00 : (reg_wr && reg_addr == 8'h00) ? reg_wdata[7:0] : ctl0_ff;
  end
  a_rst_quiet: assert property ($fell(sys_rst) |-> reg_rdata_ff == 32'h0 && !irq_ff)
    else $error("outputs busy after reset");
  a_rd_stands: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
    else $error("read data outside slot");
  a_bad_addr: assert property (reg_rd && (reg_addr[1:0] != 2'h0 || reg_addr[7:3] == 5'h11)
    |=> reg_rdata_ff == 32'h0) else $error("unmapped read not zero");
  a_sts_clear: assert property (rd_sts && !conv_vld |-> ##2 !irq_ff)
    else $error("interrupt after status clear");
  a_irq_cause: assert property ($rose(irq_ff) |-> $past(conv_vld, 2) || $past(reg_wr, 2))
    else $error("interrupt without cause");
  a_plain_store: assert property (pl0 ##1 !conv_vld ##1 (reg_rd && reg_addr == 8'h40)
    |=> reg_rdata_ff == {16'h8000, 4'h0, $past(conv_res, 3)}) else $error("plain store");
  a_sts_event: assert property (pl0 ##1 !rd_sts [*3] ##1 rd_sts |=> reg_rdata_ff[0])
    else $error("event bit missing");
  a_vld_clear: assert property (reg_rd && reg_addr[7:6] == 2'h1 && reg_addr[1:0] == 2'h0
    && !conv_vld ##1 !conv_vld
    ##1 (reg_rd && reg_addr == $past(reg_addr, 2) && !conv_vld) |=> !reg_rdata_ff[31])
    else $error("valid survived read");
  c_plain: cover property (pl0);
  c_irq: cover property ($rose(irq_ff));
  c_sts: cover property (rd_sts ##1 reg_rdata_ff != 32'h0);
endmodule

//--- test/ardm_conv_src.sv
// Conversion result source, one result per call
module ardm_conv_src (
  // Clock
  input  wire logic  mclk,
  // Results
  output logic        conv_vld,
  output logic [3:0]  conv_sel,
  output logic [11:0] conv_res
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    conv_vld = 1'b0;
    conv_sel = 4'h0;
    conv_res = 12'h0;
  end
  task automatic send(input logic [3:0] s, input logic [11:0] r);
    @(posedge mclk);
    conv_vld <= 1'b1;
    conv_sel <= s;
    conv_res <= r;
    @(posedge mclk);
    conv_vld <= 1'b0;
    // Stale lines inverted so no leftover value can pass
    conv_sel <= ~s;
    conv_res <= ~r;
  endtask
endmodule

//--- test/testbench.sv
// Scenario bench for the result data modification block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  // Enable starts high; t_ce drops it to test the freeze path
  logic        ce = 1'b1;
  logic        conv_vld;
  logic [3:0]  conv_sel;
  logic [11:0] conv_res;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff;
  logic        irq_ff;
  int          n_errors = 0;
  int          n_checks = 0;
  logic [31:0] rd_last = 32'h0;
  always #2.5 mclk = ~mclk;
  ardm_conv_src src_u (
    .mclk     (mclk),
    .conv_vld (conv_vld),
    .conv_sel (conv_sel),
    .conv_res (conv_res)
  );
  ardm_top dut_u (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .ce           (ce),
    .conv_vld     (conv_vld),
    .conv_sel     (conv_sel),
    .conv_res     (conv_res),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata_ff (reg_rdata_ff),
    .irq_ff       (irq_ff)
  );
  task automatic test_done();
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_last = reg_rdata_ff;
    chk(reg_rdata_ff, e);
  endtask
  task automatic t_regs();
    rd(8'h84, 32'h0);
    wr(8'h84, 32'h1);
    wr(8'h85, 32'hff);
    rd(8'h84, 32'h1);
    rd(8'h88, 32'h0);
    wr(8'h0c, 32'hf1);
    rd(8'h0c, 32'hf1);
    src_u.send(4'h3, 12'h5a5);
    rd(8'h4c, 32'h8000_05a5);
    // Mode 10 has no support here, so a plain store
    wr(8'h08, 32'h32);
    src_u.send(4'h2, 12'h123);
    rd(8'h48, 32'h8000_0123);
    src_u.send(4'h0, 12'h3c3);
    rd(8'h40, 32'h8000_03c3);
    rd(8'h80, 32'hd);
  endtask
  task automatic t_iir();
    logic [15:0] y;
    y = 16'h0;
    for (int c = 14; c < 16; c++) begin
      wr(8'h3c, {24'h0, c[3:0], 4'h1});
      repeat (3) begin
        src_u.send(4'hf, 12'h800);
        y = (c == 14) ? 16'h1000 + (y >> 1) : 16'h1800 + (y >> 2);
        rd(8'h7c, {16'h8000, y});
      end
    end
  endtask
  task automatic t_fir();
    logic [11:0] cf [14] = '{12'h210, 12'h120, 12'h201, 12'h111, 12'h102, 12'h310, 12'h220,
                             12'h130, 12'h301, 12'h211, 12'h121, 12'h202, 12'h112, 12'h103};
    for (int i = 0; i < 14; i++) begin
      wr(8'h1c, {24'h0, i[3:0], 4'h1});
      // Two fresh samples refill the history before the third is filtered
      src_u.send(4'h7, 12'h00f);
      src_u.send(4'h7, 12'h0f0);
      src_u.send(4'h7, 12'hf00);
      rd(8'h5c, 32'h8000_0000 | (cf[i][11:8] * 32'hf00 + cf[i][7:4] * 32'hf0 + cf[i][3:0] * 32'hf));
    end
    wr(8'h1c, 32'h31);
    repeat (3) src_u.send(4'h7, 12'h123);
    rd(8'h5c, 32'h8000_0369);
    chk({16'h0, rd_last[15:0] / 16'h3}, 32'h123);
    // Register 15 history still holds the IIR run's samples, not register 7's
    wr(8'h3c, 32'h31);
    src_u.send(4'hf, 12'h123);
    rd(8'h7c, 32'h8000_1123);
    chk({31'h0, irq_ff}, 32'h0);
    rd(8'h80, 32'h8080);
  endtask
  task automatic t_red(input logic [3:0] n);
    logic [15:0] s;
    s = 16'h0;
    wr(8'h00, {24'h0, n, 4'h0});
    for (int k = 0; k <= n; k++) begin
      src_u.send(4'h0, 12'h100 + k[11:0]);
      s = s + 16'h100 + k[15:0];
      if (k == 0) begin
        rd(8'h40, {12'h0, n, 16'h100});
        rd(8'h80, 32'h0);
      end
    end
    @(posedge mclk);
    #1 chk({31'h0, irq_ff}, 32'h1);
    rd(8'h80, 32'h1);
    rd(8'h40, {16'h8000, s});
    rd(8'h40, {16'h0, s});
    chk({31'h0, irq_ff}, 32'h0);
    repeat (n + 1) src_u.send(4'h0, 12'h001);
    src_u.send(4'h0, 12'h002);
    rd(8'h40, {12'h800, n, 16'h2});
    rd(8'h80, 32'h1);
  endtask
  task automatic t_ce();
    // Enable low: conversion and mask write must both be lost
    @(posedge mclk) ce <= 1'b0;
    src_u.send(4'h0, 12'h7ff);
    wr(8'h84, 32'hffff);
    @(posedge mclk) ce <= 1'b1;
    rd(8'h40, 32'h000f_0002);
    rd(8'h84, 32'h1);
    // Reset in mid-run returns control and value to zero
    @(posedge mclk) sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, irq_ff}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_iir();
    t_fir();
    t_red(4'h1);
    t_red(4'hf);
    t_ce();
    test_done();
  end
  initial begin
    #50us;
    n_errors++;
    test_done();
  end
endmodule
bind ardm_top ardm_chk chk_u (
  .mclk         (mclk),
  .sys_rst      (sys_rst),
  .ce           (ce),
  .conv_vld     (conv_vld),
  .conv_sel     (conv_sel),
  .conv_res     (conv_res),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rdata_ff (reg_rdata_ff),
  .irq_ff       (irq_ff)
);
